// ===== hdl/adm_pkg.sv
// Constants and types for the converter output demultiplexer and control.
// Assumes a 40 MHz system clock and an Avalon-MM register master.
package adm_pkg;

	// ************************************************************
	// Register map (byte addresses) and fields
	// ************************************************************
	localparam logic [3:0]  OFS_CTRL       = 4'h0;
	localparam logic [3:0]  OFS_FSR        = 4'h4;
	localparam logic [3:0]  OFS_STATUS     = 4'h8;
	localparam int          CTRL_DDR_BIT   = 0;
	localparam int          CTRL_EDGE_BIT  = 1;
	localparam int          CTRL_DRIVE_BIT = 2;
	localparam int          CTRL_DCC_BIT   = 3;
	localparam logic [3:0]  CTRL_RST       = 4'hD;
	localparam int          STAT_STATE_LSB = 0;
	localparam int          STAT_BUSY_BIT  = 2;
	localparam int          STAT_SLEEP_BIT = 3;
	localparam int          STAT_EXT_BIT   = 4;
	localparam int          STAT_DDR_BIT   = 5;
	localparam int          STAT_TRIM_LSB  = 8;

	// ************************************************************
	// Full-scale range coding
	// ************************************************************
	localparam int          FSR_MIN_MV     = 560;
	localparam int          FSR_MAX_MV     = 840;
	localparam int          FSR_STEPS      = 511;
	localparam int          FSR_WIDE_MV    = 820;
	localparam int          FSR_NARROW_MV  = 600;
	localparam int          FSR_RST_MV     = 700;

	function automatic logic [8:0] fsr_code(input int mv);
		return 9'((mv - FSR_MIN_MV) * FSR_STEPS / (FSR_MAX_MV - FSR_MIN_MV));
	endfunction

	localparam logic [8:0]  FSR_WIDE       = fsr_code(FSR_WIDE_MV);
	localparam logic [8:0]  FSR_NARROW     = fsr_code(FSR_NARROW_MV);
	localparam logic [8:0]  FSR_RST        = fsr_code(FSR_RST_MV);

	// ************************************************************
	// Latencies in half input clock cycles, and history taps
	// ************************************************************
	localparam int          LAT_D_HALF     = 26;
	localparam int          LAT_C_HALF     = 27;
	localparam int          LAT_B_HALF     = 28;
	localparam int          LAT_A_HALF     = 29;
	// Taps read before the shift, so one edge is already behind
	localparam int          TAP_D          = LAT_D_HALF - 1;
	localparam int          TAP_C          = LAT_C_HALF - 1;
	localparam int          TAP_B          = LAT_B_HALF - 1;
	localparam int          TAP_A          = LAT_A_HALF - 1;
	localparam int          HIST_DEPTH     = LAT_A_HALF;

	// ************************************************************
	// Calibration and phase tracking
	// ************************************************************
	localparam logic [6:0]  TRIM_REQ_CYC   = 7'h50;
	localparam logic [5:0]  PHASE_TRIM_RST = 6'h20;
	localparam logic [5:0]  PHASE_TRIM_MAX = 6'h3F;
	localparam logic [7:0]  TICK_MAX       = 8'hFF;

	typedef enum logic [1:0] {
		ST_WAIT  = 2'b00,
		ST_CAL   = 2'b01,
		ST_RUN   = 2'b11,
		ST_SLEEP = 2'b10
	} adm_state_t;

endpackage

// ===== hdl/adm_ctrl.sv
// Output demultiplexer, output clocking and control of an 8-bit converter.
// Assumes sample clock, sample data and control pins are asynchronous,
// and an Avalon-MM master on CLK for the control registers.
//
// How it works
// - Extended mode takes settings from registers, not pins
// - Pin mode: range pin high wide, low narrow
// - Extended mode accepts range code 0 to 511 (560 to 840 mV)
// - One sample on each sample clock edge
// - Four buses, each updating every two cycles
// - First bus oldest, fourth newest in group
// - Fourth and second buses: falling core, 13/14
// - Third and first buses: rising core, 13.5/14.5
// - Latencies referenced to input clock falling edge
// - SDR data edge follows edge select level
// - SDR clock at bus rate, DDR at half
// - Floating edge select pin picks DDR
// - Drive select high full, low reduced
// - Sleep request high powers down
// - Power down floats data, clock, out-of-range
// - Running calibration finishes before power down
// - Sleep at power-up holds calibration delay
// - Calibration requests ignored while powered down
// - Duty cycle correction on after reset
// - Background phase tracking runs continuously
// - Busy output high during every calibration
// - Out-of-range on all-zero or all-one codes
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

module adm_ctrl
	import adm_pkg::*;
#(
	parameter int unsigned CAL_DELAY_CYC = 33554432, // Input clock cycles
	parameter int unsigned CAL_RUN_CYC   = 1000      // System clock cycles
) (
	input  wire logic        CLK,              // System clock, 40 MHz
	input  wire logic        RST_N,            // Async reset, active low
	input  wire logic [3:0]  AV_ADDRESS,       // Byte address
	input  wire logic        AV_READ,          // Read request
	input  wire logic        AV_WRITE,         // Write request
	input  wire logic [31:0] AV_WRITEDATA,     // Write data
	input  wire logic [3:0]  AV_BYTEENABLE,    // Write byte lanes
	output logic      [31:0] AV_READDATA,      // Read data
	output logic             AV_WAITREQUEST,   // Stall
	input  wire logic        SAMPLE_CLOCK,     // Converter input clock
	input  wire logic [7:0]  SAMPLE_DATA,      // Code from the cores
	input  wire logic        EXT_CTRL_EN,      // Register control mode
	input  wire logic        RANGE_SELECT,     // Range pin
	input  wire logic        DRIVE_LEVEL_SELECT, // Drive level pin
	input  wire logic        TRANSITION_EDGE_SELECT, // Edge pin level
	input  wire logic        TRANSITION_EDGE_FLOAT,  // Edge pin at mid
	input  wire logic        SLEEP_REQUEST,    // Power-down request
	input  wire logic        TRIM_REQUEST,     // Calibration request pin
	output logic      [7:0]  FIRST_SAMPLE_BUS, // Oldest sample
	output logic      [7:0]  SECOND_SAMPLE_BUS, // Second sample
	output logic      [7:0]  THIRD_SAMPLE_BUS, // Third sample
	output logic      [7:0]  FOURTH_SAMPLE_BUS, // Newest sample
	output logic             OUTPUT_DATA_CLOCK, // Forwarded clock
	output logic             OUT_OF_RANGE,     // Clipped code flag
	output logic             OUT_OE,           // Output enable, all outs
	output logic             TRIM_IN_PROGRESS, // Calibration busy
	output logic             DRIVE_FULL,       // 1: full drive
	output logic      [8:0]  FSR_CODE,         // Range code
	output logic             DDR_MODE,         // 1: double data rate
	output logic             DCC_EN,           // Duty cycle correction
	output logic      [5:0]  PHASE_TRIM        // Sampling phase trim
);

	// ************************************************************
	// Pin synchronisers and edge detection
	// ************************************************************
	logic [15:0] sync1_r;
	logic [15:0] sync2_r;
	logic        clk3_r;
	logic        clk_s;
	logic [7:0]  data_s;
	logic        ext_s;
	logic        rng_s;
	logic        drv_s;
	logic        tes_s;
	logic        flt_s;
	logic        sleep_s;
	logic        trq_s;
	logic        rise_ev;
	logic        fall_ev;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_r <= 16'h0000;
			sync2_r <= 16'h0000;
			clk3_r  <= 1'b0;
		end else begin
			sync1_r <= {SAMPLE_CLOCK, SAMPLE_DATA, EXT_CTRL_EN, RANGE_SELECT,
				DRIVE_LEVEL_SELECT, TRANSITION_EDGE_SELECT,
				TRANSITION_EDGE_FLOAT, SLEEP_REQUEST, TRIM_REQUEST};
			sync2_r <= sync1_r;
			clk3_r  <= sync2_r[15];
		end
	end

	assign {clk_s, data_s, ext_s, rng_s, drv_s, tes_s, flt_s, sleep_s,
		trq_s} = sync2_r;
	assign rise_ev = clk_s & ~clk3_r;
	assign fall_ev = ~clk_s & clk3_r;

	// ************************************************************
	// Register file
	// ************************************************************
	logic [3:0]  ctrl_r;
	logic [8:0]  fsr_r;
	logic        wr_en;
	logic [31:0] rd_nxt;
	adm_state_t  st_r;
	adm_state_t  st_nxt;

	assign wr_en = AV_WRITE & ~AV_WAITREQUEST;

	// One wait cycle: accepted at the second edge of each request
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			AV_WAITREQUEST <= 1'b1;
			AV_READDATA    <= 32'h0000_0000;
		end else if ((AV_READ | AV_WRITE) & AV_WAITREQUEST) begin
			AV_WAITREQUEST <= 1'b0;
			if (AV_READ) begin
				AV_READDATA <= rd_nxt;
			end
		end else begin
			AV_WAITREQUEST <= 1'b1;
		end
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (AV_ADDRESS)
			OFS_CTRL:   rd_nxt[3:0] = ctrl_r;
			OFS_FSR:    rd_nxt[8:0] = fsr_r;
			OFS_STATUS: begin
				rd_nxt[STAT_STATE_LSB +: 2]  = st_r;
				rd_nxt[STAT_BUSY_BIT]        = TRIM_IN_PROGRESS;
				rd_nxt[STAT_SLEEP_BIT]       = sleep_s;
				rd_nxt[STAT_EXT_BIT]         = ext_s;
				rd_nxt[STAT_DDR_BIT]         = DDR_MODE;
				rd_nxt[STAT_TRIM_LSB +: 6]   = PHASE_TRIM;
			end
			default:    rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_r <= CTRL_RST;
			fsr_r  <= FSR_RST;
		end else if (wr_en) begin
			if (AV_ADDRESS == OFS_CTRL && AV_BYTEENABLE[0]) begin
				ctrl_r <= AV_WRITEDATA[3:0];
			end
			if (AV_ADDRESS == OFS_FSR) begin
				if (AV_BYTEENABLE[0]) begin
					fsr_r[7:0] <= AV_WRITEDATA[7:0];
				end
				if (AV_BYTEENABLE[1]) begin
					fsr_r[8] <= AV_WRITEDATA[8];
				end
			end
		end
	end

	// ************************************************************
	// Effective configuration, pins or registers
	// ************************************************************
	// Mode pin is used live; it is expected to stay put while running
	logic ddr_eff;
	logic edge_eff;
	logic edge_r;

	assign ddr_eff  = ext_s ? ctrl_r[CTRL_DDR_BIT] : flt_s;
	// Edge bit must be zero in DDR; it is ignored there regardless
	assign edge_eff = ext_s ? (ctrl_r[CTRL_EDGE_BIT] & ~ctrl_r[CTRL_DDR_BIT])
		: tes_s;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			DDR_MODE   <= 1'b0;
			edge_r     <= 1'b0;
			DRIVE_FULL <= 1'b1;
			FSR_CODE   <= FSR_RST;
			DCC_EN     <= 1'b1;
		end else begin
			DDR_MODE   <= ddr_eff;
			edge_r     <= edge_eff;
			DRIVE_FULL <= ext_s ? ctrl_r[CTRL_DRIVE_BIT] : drv_s;
			FSR_CODE   <= ext_s ? fsr_r : (rng_s ? FSR_WIDE : FSR_NARROW);
			DCC_EN     <= ctrl_r[CTRL_DCC_BIT];
		end
	end

	// ************************************************************
	// Sample history and demultiplexer
	// ************************************************************
	logic [7:0] hist_r [HIST_DEPTH];
	logic       ph_r;
	logic       upd_ev;

	function automatic logic is_clip(input logic [7:0] code);
		return (code == 8'h00) || (code == 8'hFF);
	endfunction

	// Bus group is launched on every second falling input edge
	assign upd_ev = fall_ev & ph_r;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_r[i] <= 8'h00;
			end
		end else if (rise_ev | fall_ev) begin
			hist_r[0] <= data_s;
			for (int i = 1; i < HIST_DEPTH; i++) begin
				hist_r[i] <= hist_r[i-1];
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ph_r              <= 1'b0;
			FIRST_SAMPLE_BUS  <= 8'h00;
			SECOND_SAMPLE_BUS <= 8'h00;
			THIRD_SAMPLE_BUS  <= 8'h00;
			FOURTH_SAMPLE_BUS <= 8'h00;
			OUT_OF_RANGE      <= 1'b0;
		end else begin
			if (fall_ev) begin
				ph_r <= ~ph_r;
			end
			if (upd_ev) begin
				FIRST_SAMPLE_BUS  <= hist_r[TAP_A];
				SECOND_SAMPLE_BUS <= hist_r[TAP_B];
				THIRD_SAMPLE_BUS  <= hist_r[TAP_C];
				FOURTH_SAMPLE_BUS <= hist_r[TAP_D];
				OUT_OF_RANGE      <= is_clip(hist_r[TAP_A]) |
					is_clip(hist_r[TAP_B]) | is_clip(hist_r[TAP_C]) |
					is_clip(hist_r[TAP_D]);
			end
		end
	end

	// ************************************************************
	// Forwarded output data clock
	// ************************************************************
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			OUTPUT_DATA_CLOCK <= 1'b0;
		end else if (upd_ev) begin
			if (DDR_MODE) begin
				OUTPUT_DATA_CLOCK <= ~OUTPUT_DATA_CLOCK;
			end else begin
				OUTPUT_DATA_CLOCK <= edge_r;
			end
		end else if (fall_ev && !DDR_MODE) begin
			OUTPUT_DATA_CLOCK <= ~OUTPUT_DATA_CLOCK;
		end
	end

	// ************************************************************
	// Calibration request detector
	// ************************************************************
	logic [6:0] lo_cnt_r;
	logic [6:0] hi_cnt_r;
	logic       cal_req;

	assign cal_req = fall_ev & trq_s & (lo_cnt_r == TRIM_REQ_CYC)
		& (hi_cnt_r == TRIM_REQ_CYC - 7'h01);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lo_cnt_r <= 7'h00;
			hi_cnt_r <= 7'h00;
		end else if (st_r != ST_RUN || cal_req) begin
			lo_cnt_r <= 7'h00;
			hi_cnt_r <= 7'h00;
		end else if (!trq_s) begin
			hi_cnt_r <= 7'h00;
			if (fall_ev && lo_cnt_r != TRIM_REQ_CYC) begin
				lo_cnt_r <= lo_cnt_r + 7'h01;
			end
		end else if (lo_cnt_r != TRIM_REQ_CYC) begin
			lo_cnt_r <= 7'h00;
		end else if (fall_ev) begin
			hi_cnt_r <= hi_cnt_r + 7'h01;
		end
	end

	// ************************************************************
	// Power and calibration sequencer
	// ************************************************************
	logic [31:0] dly_cnt_r;
	logic [31:0] run_cnt_r;
	logic        dly_done;
	logic        run_done;

	assign dly_done = fall_ev & ~sleep_s
		& (dly_cnt_r == 32'(CAL_DELAY_CYC - 1));
	assign run_done = run_cnt_r == 32'(CAL_RUN_CYC - 1);

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_WAIT: begin
				if (dly_done) begin
					st_nxt = ST_CAL;
				end
			end
			ST_CAL: begin
				if (run_done) begin
					st_nxt = sleep_s ? ST_SLEEP : ST_RUN;
				end
			end
			ST_RUN: begin
				if (sleep_s) begin
					st_nxt = ST_SLEEP;
				end else if (cal_req) begin
					st_nxt = ST_CAL;
				end
			end
			ST_SLEEP: begin
				if (!sleep_s) begin
					st_nxt = ST_RUN;
				end
			end
			default: st_nxt = ST_WAIT;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r             <= ST_WAIT;
			dly_cnt_r        <= 32'h0000_0000;
			run_cnt_r        <= 32'h0000_0000;
			OUT_OE           <= 1'b1;
			TRIM_IN_PROGRESS <= 1'b0;
		end else begin
			st_r             <= st_nxt;
			// Sleep held through the power-up wait floats the outputs too
			OUT_OE           <= st_nxt != ST_SLEEP
				&& !(st_nxt == ST_WAIT && sleep_s);
			TRIM_IN_PROGRESS <= st_nxt == ST_CAL;
			if (st_r == ST_WAIT && fall_ev && !sleep_s) begin
				dly_cnt_r <= dly_cnt_r + 32'h0000_0001;
			end
			run_cnt_r <= (st_r == ST_CAL && !run_done) ?
				run_cnt_r + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	// ************************************************************
	// Background phase tracking
	// ************************************************************
	// Balances high and low times; never paused, even in power down
	logic [7:0] hi_tick_r;
	logic [7:0] lo_tick_r;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			hi_tick_r  <= 8'h00;
			lo_tick_r  <= 8'h00;
			PHASE_TRIM <= PHASE_TRIM_RST;
		end else if (rise_ev) begin
			// Rising cycle is high time; else a balanced clock drifts
			hi_tick_r <= 8'h01;
			lo_tick_r <= 8'h00;
			if (hi_tick_r > lo_tick_r && PHASE_TRIM != PHASE_TRIM_MAX) begin
				PHASE_TRIM <= PHASE_TRIM + 6'h01;
			end else if (lo_tick_r > hi_tick_r && PHASE_TRIM != 6'h00) begin
				PHASE_TRIM <= PHASE_TRIM - 6'h01;
			end
		end else if (clk_s) begin
			if (hi_tick_r != TICK_MAX) begin
				hi_tick_r <= hi_tick_r + 8'h01;
			end
		end else if (lo_tick_r != TICK_MAX) begin
			lo_tick_r <= lo_tick_r + 8'h01;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_both_edges: assert property (
		(rise_ev || fall_ev) |=> hist_r[0] == $past(data_s))
		else $error("sample not taken on clock edge");
	a_bus_taps: assert property (
		upd_ev |=> FOURTH_SAMPLE_BUS == $past(hist_r[TAP_D])
			&& SECOND_SAMPLE_BUS == $past(hist_r[TAP_B]))
		else $error("falling core bus latency wrong");
	a_bus_order: assert property (
		upd_ev |=> FIRST_SAMPLE_BUS == $past(hist_r[TAP_A])
			&& THIRD_SAMPLE_BUS == $past(hist_r[TAP_C]))
		else $error("rising core bus latency wrong");
	a_sdr_edge: assert property (
		upd_ev && !DDR_MODE |=> OUTPUT_DATA_CLOCK == $past(edge_r))
		else $error("sdr data edge wrong");
	a_ddr_toggle: assert property (
		upd_ev && DDR_MODE |=> OUTPUT_DATA_CLOCK != $past(OUTPUT_DATA_CLOCK))
		else $error("ddr clock did not toggle");
	a_pin_range: assert property (
		(!ext_s && rng_s) [*2] |-> FSR_CODE == FSR_WIDE)
		else $error("wide range not selected");
	a_ext_range: assert property (
		ext_s [*2] |-> FSR_CODE == $past(fsr_r))
		else $error("register range not used");
	a_drive_pin: assert property (
		(!ext_s && !drv_s) [*2] |-> !DRIVE_FULL)
		else $error("reduced drive not selected");
	a_sleep_float: assert property (
		(st_r == ST_SLEEP || (st_r == ST_WAIT && sleep_s)) [*2]
			|-> !OUT_OE)
		else $error("outputs driven in power down");
	a_cal_finish: assert property (
		st_r == ST_CAL && !run_done |=> st_r == ST_CAL)
		else $error("calibration cut short");
	a_wait_hold: assert property (
		st_r == ST_WAIT && sleep_s |=> st_r == ST_WAIT && $stable(dly_cnt_r))
		else $error("calibration delay ran during sleep");
	a_sleep_nocal: assert property (
		st_r == ST_SLEEP |=> st_r != ST_CAL)
		else $error("calibration started from power down");
	a_busy_flag: assert property (
		TRIM_IN_PROGRESS == (st_r == ST_CAL))
		else $error("busy flag mismatch");
	a_clip_flag: assert property (
		upd_ev && is_clip(hist_r[TAP_A]) |=> OUT_OF_RANGE)
		else $error("clip not flagged");

	c_cal_cmd:  cover property (st_r == ST_RUN ##1 st_r == ST_CAL);
	c_sleep:    cover property (st_r == ST_CAL && run_done && sleep_s);
	c_ddr_upd:  cover property (upd_ev && DDR_MODE);
	c_sdr_upd:  cover property (upd_ev && !DDR_MODE && edge_r);

endmodule

// ===== tb/adm_capture.sv
// Capture model on the far side of the four output buses.
// Assumes the system clock oversamples the forwarded output clock.
`timescale 1ns/10ps

module adm_capture (
	input  wire logic       clk,     // System clock
	input  wire logic       hold,    // Ignore traffic while set
	input  wire logic       oe,      // Outputs driven
	input  wire logic       output_data_clock,    // Forwarded clock
	input  wire logic       ddr,     // Both clock edges launch
	input  wire logic       edge_hi, // SDR launch on rising edge
	input  wire logic [7:0] bus_a,   // Oldest sample
	input  wire logic [7:0] bus_b,   // Second sample
	input  wire logic [7:0] bus_c,   // Third sample
	input  wire logic [7:0] bus_d,   // Newest sample
	output int              groups,  // Groups taken
	output int              faults   // Broken sequences
);
	logic       output_data_clock_r = 1'b0;
	logic       seen_r = 1'b0;
	logic [7:0] next_r = 8'h00;
	int         grp_r  = 0;
	int         flt_r  = 0;

	// ************************************************************
	// Launch edge detection and stream reassembly
	// ************************************************************
	// Released lines carry no data, so they never feed the stream
	always @(posedge clk) begin
		output_data_clock_r <= output_data_clock;
		if (hold || oe !== 1'b1) begin
			seen_r <= 1'b0;
		end else if (output_data_clock !== output_data_clock_r && (ddr || output_data_clock === edge_hi)) begin
			grp_r  <= grp_r + 1;
			seen_r <= 1'b1;
			next_r <= 8'(bus_d + 8'h01);
			if (bus_b !== 8'(bus_a + 8'h01) || bus_c !== 8'(bus_b + 8'h01) ||
			    bus_d !== 8'(bus_c + 8'h01) || (seen_r && bus_a !== next_r)) begin
				flt_r <= flt_r + 1;
			end
		end
	end
	assign groups = grp_r;
	assign faults = flt_r;
endmodule

// ===== tb/adm_ctrl_tb.sv
// Self-checking bench for the demultiplexer and control block.
// Assumes the capture model and shortened calibration counts.
`timescale 1ns/10ps

module adm_ctrl_tb;
	import adm_pkg::*;

	// ************************************************************
	// Stimulus, outputs and counters
	// ************************************************************
	logic        clk = 0, rst_n = 0, sclk = 0, ext = 0, rng = 1, drv = 1;
	logic        edg = 1, flt = 0, slp = 1, trq = 1, rd = 0, wr = 0;
	logic        dprev = 0, bseen = 0, mon_on = 0, ex_ddr = 0, ex_edge = 0;
	logic        wq, output_data_clock, oor, oe, busy, dfull, ddr, dcc;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0000_0000, rdat;
	logic [7:0]  sdat = 8'h00, nf = 8'h00, l4 = 8'h00, ba, bb, bc, bd;
	logic [8:0]  range_select;
	logic [5:0]  ph;
	int          error_cnt = 0, n_tests = 0, cyc = 0, gap = 0, nchg = 0;
	int          grp, flts;

	adm_ctrl #(.CAL_DELAY_CYC(4), .CAL_RUN_CYC(20)) i_adm_ctrl (
		.CLK(clk), .RST_N(rst_n), .AV_ADDRESS(adr), .AV_READ(rd),
		.AV_WRITE(wr), .AV_WRITEDATA(wdat), .AV_BYTEENABLE(4'hF),
		.AV_READDATA(rdat), .AV_WAITREQUEST(wq), .SAMPLE_CLOCK(sclk),
		.SAMPLE_DATA(sdat), .EXT_CTRL_EN(ext), .RANGE_SELECT(rng),
		.DRIVE_LEVEL_SELECT(drv), .TRANSITION_EDGE_SELECT(edg),
		.TRANSITION_EDGE_FLOAT(flt), .SLEEP_REQUEST(slp),
		.TRIM_REQUEST(trq), .FIRST_SAMPLE_BUS(ba), .SECOND_SAMPLE_BUS(bb),
		.THIRD_SAMPLE_BUS(bc), .FOURTH_SAMPLE_BUS(bd),
		.OUTPUT_DATA_CLOCK(output_data_clock), .OUT_OF_RANGE(oor), .OUT_OE(oe),
		.TRIM_IN_PROGRESS(busy), .DRIVE_FULL(dfull), .FSR_CODE(range_select),
		.DDR_MODE(ddr), .DCC_EN(dcc), .PHASE_TRIM(ph));

	adm_capture i_adm_capture (
		.clk(clk), .hold(!mon_on || busy !== 1'b0), .oe(oe), .output_data_clock(output_data_clock),
		.ddr(ex_ddr), .edge_hi(ex_edge), .bus_a(ba), .bus_b(bb),
		.bus_c(bc), .bus_d(bd), .groups(grp), .faults(flts));

	initial forever #12.5 clk = ~clk;

	// Sample clock of 200 ns; each edge carries the next code
	initial begin
		#13;
		forever begin
			#50 sdat = sdat + 8'h01;
			#50 sclk = ~sclk;
			if (!sclk) nf = sdat;
		end
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [31:0] e,
	                   input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %0h seen %0h", nm, e, g);
		end
	endtask

	function automatic logic [7:0] age(input logic [7:0] k);
		return nf - k;
	endfunction

	function automatic logic oor_ex();
		logic r = 1'b0;
		for (int k = 26; k < 30; k++) r |= age(8'(k)) inside {8'h00, 8'hFF};
		return r;
	endfunction

	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr  <= a;
		wdat <= d;
		wr   <= w;
		rd   <= ~w;
		// Ends when wq drops low; only the bench timeout bounds this wait
		do begin
			@(posedge clk);
		end while (wq !== 1'b0);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic trim_req;
		@(posedge clk) trq <= 1'b0;
		repeat (82) @(negedge sclk);
		@(posedge clk) trq <= 1'b1;
		repeat (60) @(negedge sclk);
	endtask

	task automatic cal_wait(input logic nap);
		int i = 0, k = 0, lo = 0;
		while (busy !== 1'b1 && i < 4000) begin
			@(posedge clk);
			i++;
		end
		if (nap) slp <= 1'b1;
		while (busy === 1'b1 && k < 100) begin
			if (oe !== 1'b1) lo++;
			@(posedge clk);
			k++;
		end
		chk("cal_start", 1, i < 4000);
		chk("cal_length", 1, k >= 20 && k <= 21);
		chk("oe_in_cal", 0, lo);
	endtask

	task automatic stream(input logic d, input logic e);
		ex_ddr  <= d;
		ex_edge <= e;
		// History must refill after a reset or a mode change
		repeat (160) @(posedge clk);
		mon_on <= 1'b1;
		repeat (600) @(posedge clk);
		mon_on <= 1'b0;
	endtask

	// Timeout and group monitor: every launch while mon_on is set, outputs are driven and no calibration runs is judged against the codes
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			finish_test();
		end
		if (busy === 1'b1) bseen <= 1'b1;
		if (mon_on && oe === 1'b1 && busy === 1'b0 && bd !== l4) begin
			chk("first_bus", age(8'd29), ba);
			chk("second_bus", age(8'd28), bb);
			chk("third_bus", age(8'd27), bc);
			chk("fourth_bus", age(8'd26), bd);
			chk("out_of_range", oor_ex(), oor);
			chk("output_data_clock", 1'(ex_ddr ? ~dprev : ex_edge), output_data_clock);
			if (!ex_ddr) chk("output_data_clock_before", 1'(~ex_edge), dprev);
			if (nchg > 0) chk("group_gap", 16, gap);
			nchg++;
			gap = 0;
		end
		gap++;
		if (!mon_on) nchg = 0;
		l4    = bd;
		dprev = output_data_clock;
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_power;
		repeat (200) @(posedge clk);
		chk("cal_held", 0, bseen);
		chk("oe_asleep", 0, oe);
		chk("dcc_default", 1, dcc);
		av(0, OFS_CTRL, 0);
		chk("ctrl_reset", 32'h0000_000D, rdat);
		av(0, OFS_FSR, 0);
		chk("fsr_reset", 32'h0000_00FF, rdat);
		av(1, 4'hC, 32'hFFFF_FFFF);
		av(0, 4'hC, 0);
		chk("unmapped", 0, rdat);
		@(posedge clk) slp <= 1'b0;
		cal_wait(0);
		av(0, OFS_STATUS, 0);
		chk("state_run", 2'b11, rdat[1:0]);
		chk("oe_awake", 1, oe);
	endtask

	task automatic t_pins;
		logic [5:0] p0;
		p0 = ph;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			rng <= i[0];
			drv <= i[1];
			edg <= i[0];
			flt <= (i == 3);
			repeat (8) @(posedge clk);
			chk("fsr_pin", i[0] ? 474 : 73, range_select);
			chk("drive_pin", i[1], dfull);
			chk("ddr_pin", i == 3, ddr);
			stream(i == 3, i[0]);
		end
		chk("groups", 1, grp > 100);
		chk("faults", 0, flts);
		chk("phase_trim", 1, ph == p0 && ph != 6'h00 && ph != PHASE_TRIM_MAX);
	endtask

	task automatic t_ext;
		@(posedge clk) rst_n <= 1'b0;
		ext <= 1'b1;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		cal_wait(0);
		chk("ddr_ext", 1, ddr);
		chk("fsr_ext", 255, range_select);
		av(1, OFS_CTRL, 32'h0000_0002);
		rng <= 1'b0;
		drv <= 1'b1;
		flt <= 1'b1;
		repeat (8) @(posedge clk);
		chk("ddr_reg", 0, ddr);
		chk("drive_reg", 0, dfull);
		chk("dcc_reg", 0, dcc);
		stream(0, 1);
		av(1, OFS_FSR, 32'h0000_01FF);
		repeat (4) @(posedge clk);
		chk("fsr_top", 511, range_select);
		av(1, OFS_FSR, 0);
		repeat (4) @(posedge clk);
		chk("fsr_bottom", 0, range_select);
		av(1, OFS_CTRL, 32'h0000_0009);
		repeat (4) @(posedge clk);
		chk("ddr_reg", 1, ddr);
		stream(1, 0);
		chk("faults", 0, flts);
	endtask

	task automatic t_sleep;
		@(posedge clk) slp <= 1'b1;
		repeat (8) @(posedge clk);
		chk("oe_sleep", 0, oe);
		av(0, OFS_STATUS, 0);
		chk("state_sleep", 2'b10, rdat[1:0]);
		bseen <= 1'b0;
		trim_req();
		@(posedge clk) slp <= 1'b0;
		repeat (200) @(posedge clk);
		chk("cal_dropped", 0, bseen);
		chk("oe_wake", 1, oe);
		trim_req();
		cal_wait(1);
		repeat (8) @(posedge clk);
		chk("oe_after_cal", 0, oe);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_power();
		$display("test power-up done");
		t_pins();
		$display("test pin control done");
		t_ext();
		$display("test register control done");
		t_sleep();
		$display("test sleep done");
		finish_test();
	end
endmodule
